/* src/eatc_pkg.sv */
// Package: constants, encodings and carriers for the axis trigger control
package eatc_pkg;
	localparam int NUM_AXES = 4;
	localparam int AXIS_W = 2;
	localparam int POS_W = 32;
	localparam int SMP_W = 16;
	localparam int TS_W = 32;
	localparam int CNT_W = 16;
	localparam int INTERP_W = 12;
	localparam int PCNT_W = POS_W - INTERP_W;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [AXIS_W-1:0] AXIS_ONE = 2'h0;
	localparam logic [AXIS_W-1:0] AXIS_AUX = 2'h3;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CFG_BASE = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_DATA_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_LOST = 8'h0C;

	// Command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_AXIS_LSB = 4;
	localparam int CMD_ARG_LSB = 8;

	// Result register fields
	localparam int RES_BUSY_BIT = 0;
	localparam int RES_ERR_LSB = 4;
	localparam int RES_STAT_LSB = 16;

	typedef enum logic [2:0] {
		MODE_POLLED = 3'h0,
		MODE_SOFT_RT = 3'h1,
		MODE_STREAM = 3'h2,
		MODE_RECORD = 3'h3
	} eatc_mode_t;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_SET_SRC = 4'h1,
		OP_SET_EDGE = 4'h2,
		OP_CLEAR_CNT = 4'h3,
		OP_POS_QUERY = 4'h4,
		OP_READ_DATA = 4'h5,
		OP_ACK_SUPPLY = 4'h6,
		OP_ACK_LOST = 4'h7
	} eatc_op_t;

	typedef enum logic [3:0] {
		SRC_EXT_IN_1 = 4'h0,
		SRC_EXT_IN_2 = 4'h1,
		SRC_EXT_IN_3 = 4'h2,
		SRC_EXT_IN_4 = 4'h3,
		SRC_SW_CH_1 = 4'h4,
		SRC_SW_CH_2 = 4'h5,
		SRC_SW_CH_3 = 4'h6,
		SRC_SW_CH_4 = 4'h7,
		SRC_REF_PULSE = 4'h8,
		SRC_GATED_REF_AX1 = 4'h9,
		SRC_INTERVAL_CNT = 4'hA,
		SRC_PULSE_CNT = 4'hB,
		SRC_TIMER = 4'hC
	} eatc_src_t;

	typedef enum logic [1:0] {
		EDGE_RISING = 2'h0,
		EDGE_FALLING = 2'h1,
		EDGE_BOTH = 2'h2
	} eatc_edge_t;

	typedef enum logic [2:0] {
		IF_DISABLED = 3'h0,
		IF_INCR = 3'h1,
		IF_INCR_11U = 3'h2,
		IF_SERIAL = 3'h3,
		IF_SERIAL_INCR = 3'h4,
		IF_SERIAL_V2 = 3'h5
	} eatc_iface_t;

	typedef enum logic [3:0] {
		ERR_OK = 4'h0,
		ERR_BAD_PARAMETER = 4'h1,
		ERR_WRONG_INTERFACE = 4'h2,
		ERR_CANNOT_CLEAR = 4'h3,
		ERR_NOT_POLLED = 4'h4,
		ERR_NOT_CONFIGURED = 4'h5
	} eatc_err_t;

	// Per-axis incremental signals from the encoder front end
	typedef struct packed {
		logic sig_a;
		logic sig_b;
		logic reference_pulse;
	} eatc_incr_t;

	// Per-axis trigger selection
	typedef struct packed {
		eatc_src_t src;
		eatc_edge_t edge_sel;
	} eatc_trig_cfg_t;

	// Status word bits
	localparam int ST_W = 16;
	localparam int ST_SUPPLY_ERR = 0;
	localparam int ST_LOST_TRIG = 1;
	localparam int ST_REFC_VALID = 2;
	localparam int ST_SERIAL = 3;

	// Readout word indices for a channel-data read
	localparam int RD_WORDS = 9;
	localparam logic [3:0] RD_STATUS = 4'h0;
	localparam logic [3:0] RD_POS = 4'h1;
	localparam logic [3:0] RD_REF1 = 4'h2;
	localparam logic [3:0] RD_REF2 = 4'h3;
	localparam logic [3:0] RD_REFC = 4'h4;
	localparam logic [3:0] RD_TS = 4'h5;
	localparam logic [3:0] RD_CNT = 4'h6;
	localparam logic [3:0] RD_SMP_A = 4'h7;
	localparam logic [3:0] RD_SMP_B = 4'h8;
endpackage

/* src/eatc_axis_trig.sv */
// Per-axis trigger source selection and edge detection
`timescale 1ns/1ps
`default_nettype none
module eatc_axis_trig
	import eatc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Configuration
	input wire eatc_trig_cfg_t cfg,
	// Trigger sources
	input wire logic [3:0] ext_in,
	input wire logic [3:0] sw_ch,
	input wire logic ref_pulse,
	input wire logic gated_ref_ax1,
	input wire logic interval_cnt,
	input wire logic pulse_cnt,
	input wire logic timer_trig,
	// Output
	output logic trig
);
	logic ref_q_reg;
	logic gated_q_reg;
	logic sel_level;
	logic ref_rise;
	logic ref_fall;
	logic ref_evt;
	logic gated_rise;
	logic trig_next;

	// Reference edges are taken against the last sampled level
	assign ref_rise = ref_pulse & ~ref_q_reg;
	assign ref_fall = ~ref_pulse & ref_q_reg;
	assign ref_evt = (cfg.edge_sel == EDGE_RISING) ? ref_rise :
		(cfg.edge_sel == EDGE_FALLING) ? ref_fall :
		(ref_rise | ref_fall); // [RL5]
	assign gated_rise = gated_ref_ax1 & ~gated_q_reg;

	always_comb begin
		sel_level = 1'b0;
		case (cfg.src) // [RL2] [RL3] [RL4]
			SRC_EXT_IN_1: sel_level = ext_in[0];
			SRC_EXT_IN_2: sel_level = ext_in[1];
			SRC_EXT_IN_3: sel_level = ext_in[2];
			SRC_EXT_IN_4: sel_level = ext_in[3];
			SRC_SW_CH_1: sel_level = sw_ch[0];
			SRC_SW_CH_2: sel_level = sw_ch[1];
			SRC_SW_CH_3: sel_level = sw_ch[2];
			SRC_SW_CH_4: sel_level = sw_ch[3];
			SRC_REF_PULSE: sel_level = ref_evt;
			SRC_GATED_REF_AX1: sel_level = gated_rise;
			SRC_INTERVAL_CNT: sel_level = interval_cnt;
			SRC_PULSE_CNT: sel_level = pulse_cnt;
			SRC_TIMER: sel_level = timer_trig;
			default: sel_level = 1'b0;
		endcase
	end
	assign trig_next = sel_level;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ref_q_reg <= 1'b0;
			gated_q_reg <= 1'b0;
			trig <= 1'b0;
		end else begin
			ref_q_reg <= ref_pulse;
			gated_q_reg <= gated_ref_ax1;
			trig <= trig_next; // [RL21]
		end
	end
endmodule
`default_nettype wire

/* src/eatc_top.sv */
// Encoder axis trigger and acquisition control, top level
// How it works
// (RL1) Source changes only in polled mode
// (RL2) Four external, four software, reference pulse
// (RL3) Gated reference of axis 1: A&B&ref
// (RL4) Interval counter, pulse counter, timer sources
// (RL5) Reference edge rising, falling or both
// (RL6) Host keeps both-edge rate legal
// (RL7) Clear resets period count, keeps interpolation
// (RL8) Clear only on incremental axes, else error
// (RL9) Position query polled only, with status
// (RL10) Incremental interpolated value, serial sends request
// (RL11) Combined serial-incremental returns interpolated value
// (RL12) Channel read: polled mode, incremental axis
// (RL13) Channel read fires software channel 1
// (RL14) Channel read sets auxiliary source to software
// (RL15) Channel read returns the nine-word record
// (RL16) Coded reference valid only when distance coded
// (RL17) Supply acknowledge without error is rejected
// (RL18) Acknowledge turns encoder supply back on
// (RL19) Lost-trigger acknowledge clears all axes
// (RL20) Bad source or edge code rejected
// (RL21) Selections stored per axis, applied synchronously
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module eatc_top
	import eatc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Axis configuration from the initialisation block
	input wire logic [NUM_AXES*3-1:0] axis_iface,
	input wire logic [NUM_AXES-1:0] axis_dist_coded,
	// Encoder signals and counts
	input wire eatc_incr_t [NUM_AXES-1:0] incr,
	input wire logic [NUM_AXES*POS_W-1:0] axis_pos,
	input wire logic [NUM_AXES*POS_W-1:0] serial_pos,
	input wire logic [NUM_AXES-1:0] serial_done,
	input wire logic [NUM_AXES*POS_W-1:0] ref1_pos,
	input wire logic [NUM_AXES*POS_W-1:0] ref2_pos,
	input wire logic [NUM_AXES*POS_W-1:0] refc_pos,
	input wire logic [NUM_AXES*SMP_W-1:0] sample_signal_a,
	input wire logic [NUM_AXES*SMP_W-1:0] sample_signal_b,
	input wire logic [TS_W-1:0] timestamp,
	input wire logic [NUM_AXES*CNT_W-1:0] trig_count,
	// Error sources
	input wire logic [NUM_AXES-1:0] supply_fault,
	input wire logic lost_trigger_evt,
	// Shared trigger sources
	input wire logic [3:0] ext_in,
	input wire logic [3:0] sw_ch,
	input wire logic interval_cnt,
	input wire logic pulse_cnt,
	input wire logic timer_trig,
	// Outputs to the axes
	output logic [NUM_AXES-1:0] axis_trig,
	output logic [NUM_AXES-1:0] clear_period_counter,
	output logic [NUM_AXES-1:0] serial_request,
	output logic [NUM_AXES-1:0] supply_on
);
	// ===========================================================
	// Decode helpers
	function automatic logic is_incr(input logic [2:0] f);
		return f == IF_INCR || f == IF_INCR_11U;
	endfunction
	function automatic logic [POS_W-1:0] pos_of(
		input logic [NUM_AXES*POS_W-1:0] v, input logic [AXIS_W-1:0] a);
		return v[a*POS_W +: POS_W];
	endfunction
	// Combined serial-incremental axes count as neither serial nor incremental here
	function automatic logic is_serial(input logic [2:0] f);
		return f == IF_SERIAL || f == IF_SERIAL_V2;
	endfunction

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT_SERIAL = 2'h1,
		ST_CAPTURE = 2'h2
	} eatc_state_t;

	// ===========================================================
	// State
	eatc_mode_t mode_reg;
	eatc_trig_cfg_t [NUM_AXES-1:0] cfg_reg;
	logic [NUM_AXES-1:0] supply_err_reg;
	logic [NUM_AXES-1:0] lost_reg;
	eatc_state_t state_reg;
	eatc_state_t state_next;
	eatc_err_t err_reg;
	logic [AXIS_W-1:0] cur_axis_reg;
	logic [DATA_W-1:0] rec_reg [RD_WORDS];
	logic sw1_pulse_reg;
	logic [NUM_AXES-1:0] ptrig_reg;

	// ===========================================================
	// Command decode
	logic cmd_wr;
	eatc_op_t cmd_op;
	logic [AXIS_W-1:0] cmd_axis;
	logic [3:0] cmd_arg;
	logic polled;
	logic [2:0] cmd_if;
	logic cmd_incr;
	logic cmd_serial;
	logic src_ok;
	logic edge_ok;
	logic idle;
	eatc_err_t cmd_err;
	logic [ST_W-1:0] status_word;
	logic [3:0] sw_eff;

	assign cmd_wr = reg_wr && reg_addr == OFS_CMD;
	assign cmd_op = eatc_op_t'(reg_wdata[CMD_OP_LSB +: 4]);
	assign cmd_axis = reg_wdata[CMD_AXIS_LSB +: AXIS_W];
	assign cmd_arg = reg_wdata[CMD_ARG_LSB +: 4];
	assign polled = mode_reg == MODE_POLLED;
	assign cmd_if = axis_iface[cmd_axis*3 +: 3];
	assign cmd_incr = is_incr(cmd_if);
	assign cmd_serial = is_serial(cmd_if);
	assign src_ok = cmd_arg <= SRC_TIMER; // [RL20]
	assign edge_ok = cmd_arg[1:0] <= EDGE_BOTH && cmd_arg[3:2] == 2'h0;
	assign idle = state_reg == ST_IDLE;
	// Software channel 1 is also fired internally by a channel read
	assign sw_eff = {sw_ch[3:1], sw_ch[0] | sw1_pulse_reg}; // [RL13]

	always_comb begin
		cmd_err = ERR_OK;
		case (cmd_op)
			OP_SET_SRC: begin
				if (!polled) cmd_err = ERR_NOT_POLLED; // [RL1]
				else if (!src_ok) cmd_err = ERR_BAD_PARAMETER; // [RL20]
			end
			OP_SET_EDGE: begin
				if (!edge_ok) cmd_err = ERR_BAD_PARAMETER; // [RL20]
			end
			OP_CLEAR_CNT: begin
				if (!cmd_incr) cmd_err = ERR_WRONG_INTERFACE; // [RL8]
			end
			OP_POS_QUERY: begin
				if (!polled) cmd_err = ERR_NOT_POLLED; // [RL9]
				else if (cmd_if == IF_DISABLED) cmd_err = ERR_NOT_CONFIGURED;
			end
			OP_READ_DATA: begin
				if (!polled) cmd_err = ERR_NOT_POLLED; // [RL12]
				else if (!cmd_incr) cmd_err = ERR_BAD_PARAMETER; // [RL12]
			end
			OP_ACK_SUPPLY: begin
				if (!supply_err_reg[cmd_axis]) cmd_err = ERR_CANNOT_CLEAR; // [RL17]
			end
			OP_ACK_LOST: cmd_err = ERR_OK;
			default: cmd_err = ERR_BAD_PARAMETER;
		endcase
	end

	logic do_cmd;
	logic cmd_good;
	assign do_cmd = cmd_wr && idle;
	assign cmd_good = do_cmd && cmd_err == ERR_OK;

	// Status word of the current axis
	logic cmd_serial_cur;
	logic refc_valid_cur;
	logic [2:0] cur_if;
	assign cur_if = axis_iface[cur_axis_reg*3 +: 3];
	assign cmd_serial_cur = is_serial(cur_if);
	// Coded reference is only meaningful for distance-coded scales
	assign refc_valid_cur = axis_dist_coded[cur_axis_reg]; // [RL16]
	assign status_word = {{(ST_W-4){1'b0}},
		cmd_serial_cur, refc_valid_cur, lost_reg[cur_axis_reg],
		supply_err_reg[cur_axis_reg]};

	// ===========================================================
	// Query sequencer
	logic is_read_cur;
	logic is_read_reg;
	// Commands arriving while busy are dropped, not queued
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (cmd_good && cmd_op == OP_POS_QUERY && cmd_serial)
					state_next = ST_WAIT_SERIAL; // [RL10] [RL11]
				else if (cmd_good && (cmd_op == OP_POS_QUERY ||
					cmd_op == OP_READ_DATA))
					state_next = ST_CAPTURE;
			end
			ST_WAIT_SERIAL: begin
				if (serial_done[cur_axis_reg]) state_next = ST_IDLE;
			end
			ST_CAPTURE: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end
	assign is_read_cur = is_read_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			cur_axis_reg <= AXIS_ONE;
			err_reg <= ERR_OK;
			is_read_reg <= 1'b0;
			sw1_pulse_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sw1_pulse_reg <= cmd_good && cmd_op == OP_READ_DATA; // [RL13]
			if (do_cmd) begin
				cur_axis_reg <= cmd_axis;
				err_reg <= cmd_err;
				is_read_reg <= cmd_op == OP_READ_DATA;
			end
		end
	end

	// ===========================================================
	// Captured record, taken on one edge: all nine words for a channel read, only status and position for a query
	logic capture;
	assign capture = (state_reg == ST_CAPTURE) ||
		(state_reg == ST_WAIT_SERIAL && serial_done[cur_axis_reg]);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < RD_WORDS; i++) rec_reg[i] <= '0;
		end else if (capture) begin
			rec_reg[RD_STATUS] <= DATA_W'(status_word); // [RL9]
			rec_reg[RD_POS] <= (state_reg == ST_WAIT_SERIAL) ?
				pos_of(serial_pos, cur_axis_reg) :
				pos_of(axis_pos, cur_axis_reg); // [RL10] [RL11]
			if (is_read_cur) begin
				rec_reg[RD_REF1] <= pos_of(ref1_pos, cur_axis_reg); // [RL15]
				rec_reg[RD_REF2] <= pos_of(ref2_pos, cur_axis_reg);
				rec_reg[RD_REFC] <= pos_of(refc_pos, cur_axis_reg);
				rec_reg[RD_TS] <= timestamp;
				rec_reg[RD_CNT] <= DATA_W'(trig_count[cur_axis_reg*CNT_W +: CNT_W]);
				rec_reg[RD_SMP_A] <=
					DATA_W'(sample_signal_a[cur_axis_reg*SMP_W +: SMP_W]);
				rec_reg[RD_SMP_B] <=
					DATA_W'(sample_signal_b[cur_axis_reg*SMP_W +: SMP_W]);
			end
		end
	end

	// ===========================================================
	// Mode, per-axis configuration, errors and supply control
	logic lost_ack;
	assign lost_ack = cmd_good && cmd_op == OP_ACK_LOST;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= MODE_POLLED;
		end else if (reg_wr && reg_addr == OFS_MODE) begin
			mode_reg <= eatc_mode_t'(reg_wdata[2:0]);
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_AXES; g++) begin : g_axis
			logic sel_this;
			assign sel_this = cmd_good && cmd_axis == g;
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					cfg_reg[g] <= '{src: SRC_SW_CH_1, edge_sel: EDGE_RISING};
					supply_err_reg[g] <= 1'b0;
					lost_reg[g] <= 1'b0;
					supply_on[g] <= 1'b1;
					clear_period_counter[g] <= 1'b0;
					serial_request[g] <= 1'b0;
				end else begin
					if (sel_this && cmd_op == OP_SET_SRC)
						cfg_reg[g].src <= eatc_src_t'(cmd_arg); // [RL21]
					else if (cmd_good && cmd_op == OP_READ_DATA &&
						g == AXIS_AUX)
						cfg_reg[g].src <= SRC_SW_CH_1; // [RL14]
					if (sel_this && cmd_op == OP_SET_EDGE)
						cfg_reg[g].edge_sel <= eatc_edge_t'(cmd_arg[1:0]);
					// Period count only; interpolation is left alone
					clear_period_counter[g] <= sel_this &&
						cmd_op == OP_CLEAR_CNT; // [RL7]
					serial_request[g] <= sel_this && cmd_op == OP_POS_QUERY &&
						cmd_serial; // [RL10]
					// Fault wins over acknowledge in the same cycle
					if (supply_fault[g]) begin
						supply_err_reg[g] <= 1'b1;
						supply_on[g] <= 1'b0;
					end else if (sel_this && cmd_op == OP_ACK_SUPPLY) begin
						supply_err_reg[g] <= 1'b0;
						supply_on[g] <= 1'b1; // [RL18]
					end
					if (lost_trigger_evt) lost_reg[g] <= 1'b1;
					else if (lost_ack) lost_reg[g] <= 1'b0; // [RL19]
				end
			end
			eatc_axis_trig u_trig (
				.clk(clk),
				.rstn(rstn),
				.cfg(cfg_reg[g]),
				.ext_in(ext_in),
				.sw_ch(sw_eff),
				.ref_pulse(incr[g].reference_pulse),
				.gated_ref_ax1(incr[AXIS_ONE].sig_a & incr[AXIS_ONE].sig_b &
					incr[AXIS_ONE].reference_pulse), // [RL3]
				.interval_cnt(interval_cnt),
				.pulse_cnt(pulse_cnt),
				.timer_trig(timer_trig),
				.trig(ptrig_reg[g])
			);
		end
	endgenerate
	assign axis_trig = ptrig_reg;

	// ===========================================================
	// Register read port: data the cycle after the strobe
	// Reads have no side effects, so polling the result is harmless
	logic [DATA_W-1:0] rd_mux;
	logic [AXIS_W-1:0] rd_cfg_idx;
	logic [3:0] rd_rec_idx;
	assign rd_cfg_idx = reg_addr[AXIS_W+1:2];
	assign rd_rec_idx = 4'((reg_addr - OFS_DATA_BASE) >> 2);
	assign rd_mux =
		(reg_addr == OFS_MODE) ? DATA_W'(mode_reg) :
		(reg_addr == OFS_RESULT) ? DATA_W'({status_word, 8'h00, err_reg,
			3'h0, !idle}) :
		(reg_addr == OFS_LOST) ? DATA_W'({supply_err_reg, lost_reg}) :
		(reg_addr[ADDR_W-1:4] == OFS_CFG_BASE[ADDR_W-1:4] &&
			reg_addr[1:0] == 2'h0) ? DATA_W'(cfg_reg[rd_cfg_idx]) :
		(reg_addr >= OFS_DATA_BASE && rd_rec_idx < 4'(RD_WORDS) &&
			reg_addr[1:0] == 2'h0) ? rec_reg[rd_rec_idx] :
		'0;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) reg_rdata <= '0;
		else if (reg_rd) reg_rdata <= rd_mux;
		else reg_rdata <= '0;
	end
endmodule
`default_nettype wire

/* dv/eatc_top_assertions.sv */
// Checker for the axis trigger control top level
`timescale 1ns/1ps
`default_nettype none
module eatc_top_assertions
	import eatc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// Axis side
	input wire logic [NUM_AXES*3-1:0] axis_iface,
	input wire logic [NUM_AXES-1:0] supply_fault,
	input wire logic [NUM_AXES-1:0] clear_period_counter,
	input wire logic [NUM_AXES-1:0] serial_request,
	input wire logic [NUM_AXES-1:0] supply_on
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// ==========
	// Command decode
	wire logic cmd_w = reg_wr && reg_addr == OFS_CMD;
	wire logic [3:0] op = reg_wdata[3:0];
	wire logic [1:0] ax = reg_wdata[5:4];
	// ==========
	// Properties
	a_fault_drops_supply: assert property (
		supply_fault[0] |=> !supply_on[0]) else $error("supply kept on");
	a_ack_restores_supply: assert property (
		cmd_w && op == OP_ACK_SUPPLY && ax == 2'h0 && !supply_on[0] &&
		!supply_fault[0] |-> ##[1:2] supply_on[0]) else $error("no supply");
	// Supply only comes back through an acknowledge
	a_supply_stays_off: assert property (
		!supply_on[0] && !cmd_w && !$past(cmd_w) |=> !supply_on[0])
		else $error("supply back unasked");
	a_clear_incr_only: assert property (
		clear_period_counter[1] |-> axis_iface[5:3] inside {IF_INCR, IF_INCR_11U})
		else $error("clear on wrong axis");
	a_clear_on_command: assert property (
		cmd_w && op == OP_CLEAR_CNT && ax == 2'h0 && axis_iface[2:0] == IF_INCR
		|-> ##[1:2] clear_period_counter[0]) else $error("no clear pulse");
	a_combined_no_request: assert property (
		serial_request[2] |-> axis_iface[8:6] inside {IF_SERIAL, IF_SERIAL_V2})
		else $error("request on combined axis");
	a_query_sends_request: assert property (
		cmd_w && op == OP_POS_QUERY && ax == 2'h1 && axis_iface[5:3] == IF_SERIAL
		|-> ##[1:2] serial_request[1]) else $error("no serial request");
	a_read_data_quiet: assert property (
		!$past(reg_rd) |-> reg_rdata == '0) else $error("read data unasked");
endmodule
`default_nettype wire

/* dv/eatc_enc_model.sv */
// Encoder-side model: incremental levels, serial answers, supply faults
`timescale 1ns/1ps
`default_nettype none
module eatc_enc_model
	import eatc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Encoder side
	input wire logic [NUM_AXES-1:0] serial_request,
	output var eatc_incr_t [NUM_AXES-1:0] incr,
	output logic [NUM_AXES*POS_W-1:0] serial_pos,
	output logic [NUM_AXES-1:0] serial_done,
	output logic [NUM_AXES-1:0] supply_fault
);
	int dly = 0;
	int wait_c [NUM_AXES];
	initial incr = '0;
	initial supply_fault = '0;
	// Word valid only with done; inverted otherwise so stale reads show
	always_comb
		for (int a = 0; a < NUM_AXES; a++)
			serial_pos[a*POS_W+:POS_W] = serial_done[a] ?
				{24'h5E0000, 8'(a)} : ~{24'h5E0000, 8'(a)};
	// Answer after dly extra cycles, so a slow encoder can stall a query
	always @(posedge clk or negedge rstn)
		for (int a = 0; a < NUM_AXES; a++)
			if (!rstn) begin
				serial_done[a] <= 1'b0;
				wait_c[a] <= -1;
			end else begin
				serial_done[a] <= wait_c[a] == 0;
				if (serial_request[a])
					wait_c[a] <= dly;
				else if (wait_c[a] >= 0)
					wait_c[a] <= wait_c[a] - 1;
			end
	task automatic set_incr(input int a, input logic [2:0] v);
		@(posedge clk);
		incr[a] <= v;
	endtask
	task automatic fault(input int a);
		@(posedge clk);
		supply_fault[a] <= 1'b1;
		@(posedge clk);
		supply_fault[a] <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the axis trigger control
`timescale 1ns/1ps
`default_nettype none
module tb;
	import eatc_pkg::*;
	// ==========
	// Wiring
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [NUM_AXES*3-1:0] axis_iface;
	logic [NUM_AXES-1:0] axis_dist_coded = 4'h1;
	eatc_incr_t [NUM_AXES-1:0] incr;
	logic [NUM_AXES*POS_W-1:0] axis_pos, serial_pos, ref1_pos, ref2_pos;
	logic [NUM_AXES*POS_W-1:0] refc_pos;
	logic [NUM_AXES*SMP_W-1:0] sample_signal_a, sample_signal_b;
	logic [NUM_AXES*CNT_W-1:0] trig_count;
	logic [TS_W-1:0] timestamp = 32'h7157_0C3A;
	logic [NUM_AXES-1:0] serial_done, supply_fault, axis_trig, supply_on;
	logic [NUM_AXES-1:0] clear_period_counter, serial_request;
	logic lost_trigger_evt = 1'b0;
	logic [10:0] srcs = '0;
	logic [3:0] ext_in, sw_ch;
	logic interval_cnt, pulse_cnt, timer_trig;
	int fails = 0;
	int samples_checked = 0;
	int tcnt [NUM_AXES] = '{default: 0};
	assign {timer_trig, pulse_cnt, interval_cnt, sw_ch, ext_in} = srcs;
	// Axes 0 and 3 incremental, 1 serial, 2 serial with incremental
	assign axis_iface = {IF_INCR, IF_SERIAL_INCR, IF_SERIAL, IF_INCR};
	function automatic logic [31:0] pat(input int k, input int a);
		return {4'(k), 20'h3A5C1, 8'(a)};
	endfunction
	initial begin
		for (int a = 0; a < NUM_AXES; a++) begin
			axis_pos[a*POS_W+:POS_W] = pat(1, a);
			ref1_pos[a*POS_W+:POS_W] = pat(2, a);
			ref2_pos[a*POS_W+:POS_W] = pat(3, a);
			refc_pos[a*POS_W+:POS_W] = pat(4, a);
			trig_count[a*CNT_W+:CNT_W] = 16'(pat(6, a));
			sample_signal_a[a*SMP_W+:SMP_W] = 16'(pat(7, a));
			sample_signal_b[a*SMP_W+:SMP_W] = 16'(pat(8, a));
		end
	end
	initial forever #50 clk = ~clk;
	// Trigger pulses counted mid-cycle, clear of the launching edge
	always @(negedge clk)
		for (int a = 0; a < NUM_AXES; a++)
			tcnt[a] += int'(axis_trig[a] === 1'b1);
	eatc_top dut_u (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .axis_iface, .axis_dist_coded, .incr, .axis_pos,
		.serial_pos, .serial_done, .ref1_pos, .ref2_pos, .refc_pos,
		.sample_signal_a, .sample_signal_b, .timestamp, .trig_count,
		.supply_fault, .lost_trigger_evt, .ext_in, .sw_ch, .interval_cnt,
		.pulse_cnt, .timer_trig, .axis_trig, .clear_period_counter,
		.serial_request, .supply_on);
	eatc_enc_model enc_u (.clk, .rstn, .serial_request, .incr, .serial_pos,
		.serial_done, .supply_fault);
	// ==========
	// Access tasks
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
	task automatic cmd(input int op, ax, arg, output logic [3:0] e);
		logic [31:0] r;
		int n;
		n = 0;
		wr(OFS_CMD, 32'((arg << 8) | (ax << 4) | op));
		do begin
			rd(OFS_RESULT, r);
			n++;
		end while (r[RES_BUSY_BIT] !== 1'b0 && n < 40);
		chk("busy", 32'(r[RES_BUSY_BIT]), 32'h0);
		e = r[RES_ERR_LSB+:4];
	endtask
	task automatic cmd_err(input int op, ax, arg, input logic [3:0] x);
		logic [3:0] e;
		cmd(op, ax, arg, e);
		chk("err", 32'(e), 32'(x));
	endtask
	task automatic reg_chk(input int a, input logic [31:0] m, x);
		logic [31:0] d;
		rd(8'(a), d);
		chk("reg", d & m, x);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		close_out();
	end
	// ==========
	// Tests
	initial begin
		logic [3:0] ev;
		int c0;
		int c1;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a < NUM_AXES; a++)
			reg_chk(OFS_CFG_BASE + 4 * a, '1, 32'h10);
		reg_chk(8'hFC, '1, 32'h0);
		chk("supply_on", 32'(supply_on), 32'hF);
		$display("test reset done");
		for (int s = 0; s <= 12; s++) begin
			cmd_err(OP_SET_SRC, 1, s, ERR_OK);
			reg_chk(OFS_CFG_BASE + 4, '1, 32'(s << 2));
			if (s < 8 || s > 9) begin
				c0 = tcnt[1];
				@(posedge clk);
				srcs[s < 8 ? s : s - 2] <= 1'b1;
				@(posedge clk);
				srcs <= '0;
				repeat (3) @(posedge clk);
				chk("trig", tcnt[1] - c0, 1);
			end
		end
		cmd_err(OP_SET_SRC, 1, 13, ERR_BAD_PARAMETER);
		cmd_err(OP_SET_EDGE, 1, 3, ERR_BAD_PARAMETER);
		reg_chk(OFS_CFG_BASE + 4, '1, 32'h30);
		$display("test sources done");
		cmd_err(OP_SET_SRC, 0, SRC_REF_PULSE, ERR_OK);
		for (int e = 0; e < 3; e++) begin
			cmd_err(OP_SET_EDGE, 0, e, ERR_OK);
			c0 = tcnt[0];
			enc_u.set_incr(0, 3'b001);
			repeat (4) @(posedge clk);
			c1 = tcnt[0];
			enc_u.set_incr(0, 3'b000);
			repeat (4) @(posedge clk);
			chk("rise", c1 - c0, int'(e != 1));
			chk("fall", tcnt[0] - c1, int'(e != 0));
		end
		cmd_err(OP_SET_SRC, 2, SRC_GATED_REF_AX1, ERR_OK);
		for (int g = 0; g < 2; g++) begin
			c0 = tcnt[2];
			enc_u.set_incr(0, g ? 3'b111 : 3'b001);
			repeat (4) @(posedge clk);
			enc_u.set_incr(0, 3'b000);
			repeat (4) @(posedge clk);
			chk("gated", int'(tcnt[2] > c0), g);
		end
		$display("test edges done");
		wr(OFS_MODE, 32'(MODE_STREAM));
		cmd_err(OP_SET_SRC, 1, SRC_SW_CH_2, ERR_NOT_POLLED);
		reg_chk(OFS_CFG_BASE + 4, '1, 32'h30);
		cmd(OP_POS_QUERY, 0, 0, ev);
		chk("query", int'(ev != ERR_OK), 1);
		cmd(OP_READ_DATA, 0, 0, ev);
		chk("read", int'(ev != ERR_OK), 1);
		wr(OFS_MODE, 32'(MODE_POLLED));
		cmd_err(OP_CLEAR_CNT, 0, 0, ERR_OK);
		cmd_err(OP_CLEAR_CNT, 1, 0, ERR_WRONG_INTERFACE);
		$display("test mode done");
		cmd_err(OP_POS_QUERY, 0, 0, ERR_OK);
		reg_chk(OFS_DATA_BASE + 4, '1, pat(1, 0));
		enc_u.dly = 5;
		cmd_err(OP_POS_QUERY, 1, 0, ERR_OK);
		reg_chk(OFS_DATA_BASE + 4, '1, 32'h5E00_0001);
		reg_chk(OFS_DATA_BASE, 32'h8, 32'h8);
		cmd_err(OP_POS_QUERY, 2, 0, ERR_OK);
		reg_chk(OFS_DATA_BASE + 4, '1, pat(1, 2));
		$display("test query done");
		cmd_err(OP_SET_SRC, 3, SRC_TIMER, ERR_OK);
		c0 = tcnt[3];
		cmd_err(OP_READ_DATA, 0, 0, ERR_OK);
		chk("sw1", int'(tcnt[3] > c0), 1);
		reg_chk(OFS_CFG_BASE + 12, '1, 32'h10);
		for (int i = 1; i < RD_WORDS; i++)
			reg_chk(OFS_DATA_BASE + 4 * i, '1, i == 5 ? timestamp :
				i > 5 ? 32'(16'(pat(i, 0))) : pat(i, 0));
		reg_chk(OFS_DATA_BASE, 32'h4, 32'h4);
		cmd_err(OP_READ_DATA, 3, 0, ERR_OK);
		reg_chk(OFS_DATA_BASE, 32'h4, 32'h0);
		cmd_err(OP_READ_DATA, 1, 0, ERR_BAD_PARAMETER);
		$display("test channel read done");
		cmd_err(OP_ACK_SUPPLY, 0, 0, ERR_CANNOT_CLEAR);
		enc_u.fault(0);
		reg_chk(OFS_LOST, 32'hF0, 32'h10);
		chk("supply_on", 32'(supply_on), 32'hE);
		cmd_err(OP_ACK_SUPPLY, 0, 0, ERR_OK);
		chk("supply_on", 32'(supply_on), 32'hF);
		@(posedge clk);
		lost_trigger_evt <= 1'b1;
		@(posedge clk);
		lost_trigger_evt <= 1'b0;
		reg_chk(OFS_LOST, '1, 32'hF);
		cmd_err(OP_ACK_LOST, 2, 0, ERR_OK);
		reg_chk(OFS_LOST, '1, 32'h0);
		$display("test errors done");
		close_out();
	end
endmodule
bind eatc_top eatc_top_assertions chk_u (.clk(clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .axis_iface(axis_iface),
	.supply_fault(supply_fault), .clear_period_counter(clear_period_counter),
	.serial_request(serial_request), .supply_on(supply_on));
`default_nettype wire
